/* File: rtl/dad_arith_datapath.sv */
// Arithmetic datapath: ALU, accumulator, multiplier and shifters behind AXI4-Lite
`include "dad_params.svh"

module dad_arith_datapath
  import dad_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_inhibit
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Merge written bytes into an old word under the byte strobes
  function automatic logic [31:0] strb_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Signed 32-bit add with overflow taken from the two sign carries
  function automatic logic [32:0] add_ovf(
    input logic [31:0] a,
    input logic [31:0] b,
    input logic cin
  );
    logic [31:0] low;
    logic [1:0] top;
    low = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0, cin};
    top = {1'b0, a[31]} + {1'b0, b[31]} + {1'b0, low[31]};
    return {top[1] ^ low[31], top[0], low[30:0]};
  endfunction

  // Signed 16x16 product; operands widen before the multiply so no bits are lost
  function automatic logic [31:0] smul(
    input logic [15:0] a,
    input logic [15:0] b
  );
    logic signed [31:0] r;
    r = $signed(a) * $signed(b);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  logic [31:0] acc_q;
  logic [15:0] mcand_q;
  logic [31:0] prod_q;
  logic [15:0] data_q;
  logic [31:0] cmd_q;
  logic [15:0] store_q;
  logic sat_q;
  logic excess_q;
  logic branch_q;
  logic inhibit_q;
  logic [5:0] cond_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------

  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic wr_hit;
  logic cmd_fire;
  logic status_wr;
  logic data_wr;

  assign aw_hs = s_axi_awvalid && awready_q;
  assign w_hs = s_axi_wvalid && wready_q;
  // Address and data may arrive in either order; commit once both are held
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit = (awaddr_q == `DAD_ADDR_DATA) || (awaddr_q == `DAD_ADDR_CMD)
                  || (awaddr_q == `DAD_ADDR_STATUS);
  assign cmd_fire = wr_go && (awaddr_q == `DAD_ADDR_CMD);
  assign status_wr = wr_go && (awaddr_q == `DAD_ADDR_STATUS);
  assign data_wr = wr_go && (awaddr_q == `DAD_ADDR_DATA);

  // Write address capture
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      awready_q <= 1'b1;
    end
    else if (aw_hs)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      awready_q <= 1'b0;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      wready_q <= 1'b1;
    end
    else if (w_hs)
    begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      wready_q <= 1'b0;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped or read-only offsets answer with an error
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `DAD_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `DAD_RESP_OKAY : `DAD_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operand register and command decode
  // ----------------------------------------------------------------

  dad_op_t op;
  logic [3:0] sh;
  logic [15:0] imm_ext;
  logic [31:0] data_m;

  assign data_m = strb_merge({16'h0, data_q}, wdata_q, wstrb_q);
  assign op = dad_op_t'(wdata_q[`DAD_CMD_OP_HI:0]);
  assign sh = wdata_q[`DAD_CMD_SH_HI:`DAD_CMD_SH_LO];
  // Immediate is right-justified and sign-extended to a full multiplier word
  assign imm_ext = {{3{wdata_q[`DAD_CMD_IMM_HI]}},
                    wdata_q[`DAD_CMD_IMM_HI:`DAD_CMD_IMM_LO]};

  // Data word stands in for the data RAM read port
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_q <= 16'h0;
      cmd_q <= 32'h0;
    end
    else
    begin
      if (data_wr)
      begin
        data_q <= data_m[15:0];
      end
      if (cmd_fire)
      begin
        cmd_q <= wdata_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shifters and ALU
  // ----------------------------------------------------------------

  logic [31:0] shifted;
  logic [31:0] unsigned_low;
  logic [32:0] sum_r;
  logic [32:0] sum_l;
  logic [32:0] sum_p;
  logic [32:0] dif_r;
  logic [32:0] dif_l;
  logic [32:0] dif_p;
  logic [31:0] out_sh;

  // Sign-extend then shift left, zero-filling the vacated low bits
  assign shifted = {{16{data_q[15]}}, data_q} << sh;
  // Unsigned variants see the word as a plain 16-bit magnitude
  assign unsigned_low = {16'h0, data_q};
  assign sum_r = add_ovf(acc_q, shifted, 1'b0);
  assign dif_r = add_ovf(acc_q, ~shifted, 1'b1);
  assign sum_l = add_ovf(acc_q, unsigned_low, 1'b0);
  assign dif_l = add_ovf(acc_q, ~unsigned_low, 1'b1);
  assign sum_p = add_ovf(acc_q, prod_q, 1'b0);
  assign dif_p = add_ovf(acc_q, ~prod_q, 1'b1);
  // Output shifter handles only 0, 1 and 4; other codes store unshifted
  assign out_sh = (sh == 4'h1) ? {acc_q[30:0], 1'b0} :
                  (sh == 4'h4) ? {acc_q[27:0], 4'h0} : acc_q;

  // Clamp on overflow in saturate mode, otherwise keep the wrapped sum
  function automatic logic [31:0] settle(
    input logic [32:0] s,
    input logic [31:0] a,
    input logic sat
  );
    logic [31:0] r;
    r = s[31:0];
    if (s[32] && sat)
    begin
      r = a[31] ? `DAD_MAX_NEG : `DAD_MAX_POS;
    end
    return r;
  endfunction

  logic [31:0] acc_d;
  logic acc_we;
  logic ovf;

  // Accumulator next value; the accumulator is always the destination
  always_comb
  begin
    acc_d = acc_q;
    acc_we = 1'b0;
    ovf = 1'b0;
    case (op)
      DAD_OP_LOAD_SHIFTED:
      begin
        acc_d = shifted;
        acc_we = 1'b1;
      end
      DAD_OP_ADD_SHIFTED:
      begin
        acc_d = settle(sum_r, acc_q, sat_q);
        ovf = sum_r[32];
        acc_we = 1'b1;
      end
      DAD_OP_SUB_SHIFTED:
      begin
        acc_d = settle(dif_r, acc_q, sat_q);
        ovf = dif_r[32];
        acc_we = 1'b1;
      end
      DAD_OP_ADD_UNSIGNED_LOW:
      begin
        acc_d = settle(sum_l, acc_q, sat_q);
        ovf = sum_l[32];
        acc_we = 1'b1;
      end
      DAD_OP_SUBTRACT_UNSIGNED_LOW:
      begin
        acc_d = settle(dif_l, acc_q, sat_q);
        ovf = dif_l[32];
        acc_we = 1'b1;
      end
      DAD_OP_XOR:
      begin
        acc_d = {acc_q[31:16] ^ 16'h0, acc_q[15:0] ^ data_q};
        acc_we = 1'b1;
      end
      DAD_OP_AND:
      begin
        acc_d = {acc_q[31:16] & 16'h0, acc_q[15:0] & data_q};
        acc_we = 1'b1;
      end
      DAD_OP_OR:
      begin
        acc_d = {acc_q[31:16] | 16'h0, acc_q[15:0] | data_q};
        acc_we = 1'b1;
      end
      DAD_OP_T_LOAD_AND_ACCUM, DAD_OP_T_LOAD_AND_MOVE, DAD_OP_ADD_PRODUCT:
      begin
        acc_d = settle(sum_p, acc_q, sat_q);
        ovf = sum_p[32];
        acc_we = 1'b1;
      end
      DAD_OP_SUBTRACT_PRODUCT:
      begin
        acc_d = settle(dif_p, acc_q, sat_q);
        ovf = dif_p[32];
        acc_we = 1'b1;
      end
      DAD_OP_COPY_PRODUCT:
      begin
        acc_d = prod_q;
        acc_we = 1'b1;
      end
      default:
      begin
        acc_d = acc_q;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------

  // Accumulator; stores only read it, so a shifted store leaves it intact
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      acc_q <= 32'h0;
    end
    else if (cmd_fire && acc_we)
    begin
      acc_q <= acc_d;
    end
  end

  // Saturate mode bit: set or cleared by its ops, or by a status write
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sat_q <= 1'b0;
    end
    else if (cmd_fire && op == DAD_OP_SATURATE_ON)
    begin
      sat_q <= 1'b1;
    end
    else if (cmd_fire && op == DAD_OP_SATURATE_OFF)
    begin
      sat_q <= 1'b0;
    end
    else if (status_wr && wstrb_q[0])
    begin
      sat_q <= wdata_q[`DAD_ST_SAT];
    end
  end

  // Excess flag is sticky; a branch-on-excess clears it, a status write loads it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      excess_q <= 1'b0;
    end
    else if (cmd_fire && ovf)
    begin
      excess_q <= 1'b1;
    end
    else if (cmd_fire && op == DAD_OP_BRANCH_ON_EXCESS)
    begin
      excess_q <= 1'b0;
    end
    else if (status_wr && wstrb_q[0])
    begin
      excess_q <= wdata_q[`DAD_ST_EXCESS];
    end
  end

  // Branch decision of the last branch-on-excess, kept for software
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      branch_q <= 1'b0;
    end
    else if (cmd_fire && op == DAD_OP_BRANCH_ON_EXCESS)
    begin
      branch_q <= excess_q;
    end
  end

  // Accumulator conditions: lt, le, gt, ge, ne, eq, from the settled value
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cond_q <= `DAD_COND_RESET;
    end
    else
    begin
      cond_q[0] <= acc_q[31];
      cond_q[1] <= acc_q[31] || (acc_q == 32'h0);
      cond_q[2] <= !acc_q[31] && (acc_q != 32'h0);
      cond_q[3] <= !acc_q[31];
      cond_q[4] <= (acc_q != 32'h0);
      cond_q[5] <= (acc_q == 32'h0);
    end
  end

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------

  logic [31:0] mul_ram;
  logic [31:0] mul_imm;
  logic is_t_load;

  assign mul_ram = smul(mcand_q, data_q);
  assign mul_imm = smul(mcand_q, imm_ext);
  assign is_t_load = (op == DAD_OP_T_REG_LOAD) || (op == DAD_OP_T_LOAD_AND_ACCUM)
                     || (op == DAD_OP_T_LOAD_AND_MOVE);

  // Multiplicand register, loaded by the three multiplicand loads
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mcand_q <= 16'h0;
    end
    else if (cmd_fire && is_t_load)
    begin
      mcand_q <= data_q;
    end
  end

  // Product register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prod_q <= 32'h0;
    end
    else if (cmd_fire && op == DAD_OP_PRODUCT_FROM_RAM)
    begin
      prod_q <= mul_ram;
    end
    else if (cmd_fire && op == DAD_OP_PRODUCT_FROM_IMMEDIATE)
    begin
      prod_q <= mul_imm;
    end
  end

  // Hold off interrupts through the op after a multiply, since the
  // product register cannot be restored by an interrupt handler
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      inhibit_q <= 1'b0;
    end
    else if (cmd_fire)
    begin
      inhibit_q <= (op == DAD_OP_PRODUCT_FROM_RAM) ||
                   (op == DAD_OP_PRODUCT_FROM_IMMEDIATE);
    end
  end

  // ----------------------------------------------------------------
  // Store path
  // ----------------------------------------------------------------

  // Word headed for data memory; high and low halves are separate ops
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      store_q <= 16'h0;
    end
    else if (cmd_fire && op == DAD_OP_STORE_HIGH_WORD)
    begin
      store_q <= out_sh[31:16];
    end
    else if (cmd_fire && op == DAD_OP_STORE_LOW_WORD)
    begin
      store_q <= acc_q[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------

  logic [31:0] status_word;

  assign status_word = {15'h0, branch_q, 2'h0, cond_q, 5'h0,
                        inhibit_q, sat_q, excess_q};

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `DAD_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `DAD_RESP_OKAY;
      case (s_axi_araddr)
        `DAD_ADDR_DATA: rdata_q <= {16'h0, data_q};
        `DAD_ADDR_CMD: rdata_q <= cmd_q;
        `DAD_ADDR_STATUS: rdata_q <= status_word;
        `DAD_ADDR_ACC: rdata_q <= acc_q;
        `DAD_ADDR_PROD: rdata_q <= prod_q;
        `DAD_ADDR_MCAND: rdata_q <= {16'h0, mcand_q};
        `DAD_ADDR_STORE: rdata_q <= {16'h0, store_q};
        default:
        begin
          rdata_q <= 32'h0;
          rresp_q <= `DAD_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq_inhibit = inhibit_q;

endmodule

/* File: rtl/dad_params.svh */
// Offsets, field positions, reset values and codes of the arithmetic datapath
// What this block does
// - Operands and results are two's complement signed numbers, except the data word of unsigned add and subtract.
// - The ALU is 32 bits; accumulator is destination and primary operand.
// - Add, subtract, xor, and, or each combine an operand with the accumulator.
// - Logical ops use the data word on bits 15:0 and zero on 31:16.
// - Saturate-on sets and saturate-off clears the saturate mode bit.
// - Saturate mode clamps an overflowed result to the extreme of its sign.
// - Without saturate mode the wrapped result is loaded unchanged.
// - The saturate mode bit reads as one bit of the status word.
// - High and low accumulator words are stored by separate operations.
// - Excess flag is sticky until branch-on-excess or a direct status write.
// - Six accumulator conditions are provided for branching.
// - A 16-bit multiplicand and 32-bit product register; three multiplicand loads.
// - Register multiply leaves multiplicand times data word in the product register.
// - Immediate multiply uses a sign-extended 13-bit constant.
// - Product can be added, subtracted or loaded; combined loads also add it.
// - Interrupts are held off until the instruction after a multiply.
// - Input shifter shifts the data word left 0 to 15 for load, add, sub.
// - Input shifter zero-fills low bits and sign-extends to 32 bits.
// - Unsigned add and subtract use the data word without sign extension.
// - Store-high shifts the accumulator left 0, 1 or 4 and stores bits 31:16.
// - A shifted store leaves the accumulator unchanged.
`ifndef DAD_PARAMS_SVH
`define DAD_PARAMS_SVH
`define DAD_ADDR_DATA 8'h00
`define DAD_ADDR_CMD 8'h04
`define DAD_ADDR_STATUS 8'h08
`define DAD_ADDR_ACC 8'h0c
`define DAD_ADDR_PROD 8'h10
`define DAD_ADDR_MCAND 8'h14
`define DAD_ADDR_STORE 8'h18
`define DAD_CMD_OP_HI 4
`define DAD_CMD_SH_HI 11
`define DAD_CMD_SH_LO 8
`define DAD_CMD_IMM_HI 28
`define DAD_CMD_IMM_LO 16
`define DAD_ST_EXCESS 0
`define DAD_ST_SAT 1
`define DAD_ST_INHIBIT 2
`define DAD_ST_COND_LO 8
`define DAD_ST_BRANCH 16
`define DAD_COND_RESET 6'h2a
`define DAD_MAX_POS 32'h7fffffff
`define DAD_MAX_NEG 32'h80000000
`define DAD_RESP_OKAY 2'h0
`define DAD_RESP_SLVERR 2'h2
`endif

/* File: rtl/dad_pkg.sv */
// Types shared by the arithmetic datapath
package dad_pkg;
  typedef enum logic [4:0] {
    DAD_OP_NOP = 5'h00,
    DAD_OP_LOAD_SHIFTED = 5'h01,
    DAD_OP_ADD_SHIFTED = 5'h02,
    DAD_OP_SUB_SHIFTED = 5'h03,
    DAD_OP_ADD_UNSIGNED_LOW = 5'h04,
    DAD_OP_SUBTRACT_UNSIGNED_LOW = 5'h05,
    DAD_OP_XOR = 5'h06,
    DAD_OP_AND = 5'h07,
    DAD_OP_OR = 5'h08,
    DAD_OP_SATURATE_ON = 5'h09,
    DAD_OP_SATURATE_OFF = 5'h0a,
    DAD_OP_BRANCH_ON_EXCESS = 5'h0b,
    DAD_OP_STORE_HIGH_WORD = 5'h0c,
    DAD_OP_STORE_LOW_WORD = 5'h0d,
    DAD_OP_T_REG_LOAD = 5'h0e,
    DAD_OP_T_LOAD_AND_ACCUM = 5'h0f,
    DAD_OP_T_LOAD_AND_MOVE = 5'h10,
    DAD_OP_PRODUCT_FROM_RAM = 5'h11,
    DAD_OP_PRODUCT_FROM_IMMEDIATE = 5'h12,
    DAD_OP_ADD_PRODUCT = 5'h13,
    DAD_OP_SUBTRACT_PRODUCT = 5'h14,
    DAD_OP_COPY_PRODUCT = 5'h15
  } dad_op_t;
endpackage

/* File: tb/dad_arith_datapath_props.sv */
// Bus timing and interrupt-inhibit checks on the datapath ports
`include "dad_params.svh"
module dad_arith_datapath_props
  import dad_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic irq_inhibit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Helpers
  // ----
  logic w_go;
  logic cmd_go;
  logic mul_go;
  // Both write halves taken at one edge; a CMD write runs one operation
  assign w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign cmd_go = w_go && s_axi_awaddr == `DAD_ADDR_CMD;
  assign mul_go = cmd_go && (s_axi_wdata[4:0] == DAD_OP_PRODUCT_FROM_RAM || s_axi_wdata[4:0] == DAD_OP_PRODUCT_FROM_IMMEDIATE);
  // ----
  // Properties
  // ----
  property p_b_answer; w_go |-> ##2 s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response missing");
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write taken while answering");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer missing");
  property p_w_err; w_go && s_axi_awaddr >= 8'h0c |-> ##2 s_axi_bresp == `DAD_RESP_SLVERR; endproperty
  a_w_err: assert property (p_w_err) else $error("read-only write accepted");
  property p_w_ok; w_go && s_axi_awaddr <= 8'h08 |-> ##2 s_axi_bresp == `DAD_RESP_OKAY; endproperty
  a_w_ok: assert property (p_w_ok) else $error("writable register refused");
  property p_inh_set; mul_go |-> ##2 irq_inhibit; endproperty
  a_inh_set: assert property (p_inh_set) else $error("inhibit not raised");
  // Inhibit may only fall through a committed operation
  property p_inh_hold; irq_inhibit && !cmd_go && !$past(cmd_go) |=> irq_inhibit; endproperty
  a_inh_hold: assert property (p_inh_hold) else $error("inhibit dropped early");
  property p_inh_clr; cmd_go && !mul_go |-> ##2 !irq_inhibit; endproperty
  a_inh_clr: assert property (p_inh_clr) else $error("inhibit stuck");
endmodule

bind dad_arith_datapath dad_arith_datapath_props i_dad_arith_datapath_props (.*);

/* File: tb/dad_decoder_model.sv */
// Decoder-side bus model issuing register accesses to the datapath
module dad_decoder_model
(
  input wire logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic timed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus; full strobes, one word per register
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, timed_out} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Write: halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int gap);
    int n = 0;
    repeat (gap + 1) @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      // Released lines are inverted so stale values never look valid
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100) timed_out <= 1'b1;
  endtask
  // Read: address held until taken, rready held until data seen
  task automatic rd(input logic [7:0] a, input int gap);
    int n = 0;
    repeat (gap + 1) @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100) timed_out <= 1'b1;
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the arithmetic datapath
`include "dad_params.svh"
module tb_top
  import dad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ACC = `DAD_ADDR_ACC, STS = `DAD_ADDR_STATUS, PRD = `DAD_ADDR_PROD;
  localparam logic [7:0] MCD = `DAD_ADDR_MCAND, STO = `DAD_ADDR_STORE;
  logic clk, reset_n, timed_out, irq_inhibit;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, a;
  logic [3:0] s_axi_wstrb, s;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_r[$], er;
  logic [1:0] exp_b[$];
  int err_total, comparisons, i;
  dad_arith_datapath i_dad_arith_datapath (.*);
  dad_decoder_model i_dad_decoder_model (.*);
  // ----
  // Helpers
  // ----
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // Xorshift keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status word from flags {branch, inhibit, saturate, excess} and accumulator
  function automatic logic [31:0] st(input logic [3:0] f, input logic [31:0] v);
    logic z;
    z = (v == 32'h0);
    return {15'h0, f[3], 2'h0, z, ~z, ~v[31], ~v[31] & ~z, v[31] | z, v[31], 5'h0, f[2:0]};
  endfunction
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r = `DAD_RESP_OKAY);
    exp_r.push_back({r, e});
    i_dad_decoder_model.rd(ad, int'(rnd() % 3));
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = `DAD_RESP_OKAY);
    exp_b.push_back(r);
    i_dad_decoder_model.wr(ad, d, int'(rnd() % 3));
  endtask
  // Operand write, then command write
  task automatic op(input dad_op_t o, input logic [15:0] d = 16'h0, input logic [3:0] sh = 4'h0,
    input logic [12:0] k = 13'h0);
    wr(`DAD_ADDR_DATA, {16'h0, d});
    wr(`DAD_ADDR_CMD, {3'h0, k, 4'h0, sh, 3'h0, o});
  endtask
  task automatic wrap_up();
    if (exp_r.size() + exp_b.size() != 0) err_total++;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Each response is matched against the oldest note
  always @(posedge clk)
  begin
    if (timed_out)
    begin
      err_total++;
      wrap_up();
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      er = exp_r.size() ? exp_r.pop_front() : '1;
      cmp("rdata", er[31:0], s_axi_rdata);
      cmp("rresp", er[33:32], s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", exp_b.pop_front(), s_axi_bresp);
  end
  // ----
  // Scenarios
  // ----
  initial
  begin
    seed = 32'd75;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(STS, st(4'h0, 32'h0));
    rd(PRD, 32'h0);
    rd(8'h1c, 32'h0, `DAD_RESP_SLVERR);
    wr(8'h1c, 32'h1, `DAD_RESP_SLVERR);
    wr(ACC, 32'h1, `DAD_RESP_SLVERR);
    rd(ACC, 32'h0);
    $display("test reset finished");
    op(DAD_OP_LOAD_SHIFTED, 16'h7ebc, 4'h4);
    rd(ACC, 32'h0007ebc0);
    op(DAD_OP_LOAD_SHIFTED, 16'h8ebc, 4'h8);
    rd(ACC, 32'hff8ebc00);
    for (i = 0; i < 6; i++)
    begin
      a = rnd();
      op(DAD_OP_LOAD_SHIFTED, a[15:0], a[19:16]);
      rd(ACC, {{16{a[15]}}, a[15:0]} << a[19:16]);
    end
    $display("test shifter finished");
    op(DAD_OP_LOAD_SHIFTED, 16'h7fff, 4'hf);
    op(DAD_OP_ADD_SHIFTED, 16'h7fff, 4'hf);
    rd(STS, st(4'h0, 32'h7fff0000));
    op(DAD_OP_ADD_SHIFTED, 16'h7fff, 4'hf);
    rd(ACC, 32'hbffe8000);
    op(DAD_OP_SUB_SHIFTED, 16'h0001);
    rd(STS, st(4'h1, 32'hbffe7fff));
    op(DAD_OP_BRANCH_ON_EXCESS);
    rd(STS, st(4'h8, 32'hbffe7fff));
    op(DAD_OP_BRANCH_ON_EXCESS);
    rd(STS, st(4'h0, 32'hbffe7fff));
    $display("test wrap finished");
    op(DAD_OP_SATURATE_ON);
    op(DAD_OP_LOAD_SHIFTED, 16'h7fff, 4'hf);
    op(DAD_OP_ADD_SHIFTED, 16'h7fff, 4'hf);
    op(DAD_OP_ADD_SHIFTED, 16'h7fff, 4'hf);
    rd(ACC, 32'h7fffffff);
    op(DAD_OP_LOAD_SHIFTED, 16'h8000, 4'hf);
    op(DAD_OP_SUB_SHIFTED, 16'h7fff, 4'hf);
    op(DAD_OP_SUB_SHIFTED, 16'h7fff, 4'hf);
    rd(STS, st(4'h3, 32'h80000000));
    wr(STS, 32'h2);
    rd(STS, st(4'h2, 32'h80000000));
    op(DAD_OP_SATURATE_OFF);
    rd(STS, st(4'h0, 32'h80000000));
    $display("test saturate finished");
    op(DAD_OP_LOAD_SHIFTED, 16'h8000);
    op(DAD_OP_XOR, 16'h00ff);
    rd(ACC, 32'hffff80ff);
    op(DAD_OP_AND, 16'h0f0f);
    rd(ACC, 32'h0000000f);
    op(DAD_OP_OR, 16'ha5a0);
    rd(ACC, 32'h0000a5af);
    op(DAD_OP_LOAD_SHIFTED, 16'h0);
    op(DAD_OP_ADD_UNSIGNED_LOW, 16'h8000);
    rd(ACC, 32'h00008000);
    op(DAD_OP_SUBTRACT_UNSIGNED_LOW, 16'hffff);
    rd(ACC, 32'hffff8001);
    $display("test logic finished");
    op(DAD_OP_T_REG_LOAD, 16'h1234);
    rd(MCD, 32'h00001234);
    op(DAD_OP_PRODUCT_FROM_RAM, 16'hfffe);
    rd(PRD, 32'hffffdb98);
    rd(STS, st(4'h4, 32'hffff8001));
    op(DAD_OP_COPY_PRODUCT);
    rd(STS, st(4'h0, 32'hffffdb98));
    op(DAD_OP_PRODUCT_FROM_IMMEDIATE, 16'h0, 4'h0, 13'h1fff);
    rd(PRD, 32'hffffedcc);
    op(DAD_OP_ADD_PRODUCT);
    rd(ACC, 32'hffffc964);
    op(DAD_OP_SUBTRACT_PRODUCT);
    rd(ACC, 32'hffffdb98);
    op(DAD_OP_T_LOAD_AND_ACCUM, 16'h0002);
    rd(ACC, 32'hffffc964);
    op(DAD_OP_T_LOAD_AND_MOVE, 16'h0003);
    rd(ACC, 32'hffffb730);
    rd(MCD, 32'h00000003);
    $display("test multiply finished");
    op(DAD_OP_LOAD_SHIFTED, 16'h7ebc, 4'h4);
    for (i = 0; i < 3; i++)
    begin
      s = (i == 2) ? 4'h4 : 4'(i);
      op(DAD_OP_STORE_HIGH_WORD, 16'h0, s);
      a = 32'h0007ebc0 << s;
      rd(STO, {16'h0, a[31:16]});
    end
    op(DAD_OP_STORE_LOW_WORD);
    rd(STO, 32'h0000ebc0);
    op(DAD_OP_NOP);
    rd(ACC, 32'h0007ebc0);
    $display("test store finished");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
